// File: src/tpdio_pkg.sv
// Register map, field positions and carrier types for the triple-port digital I/O block
package tpdio_pkg;
  localparam logic [3:0] OFF_PORT0 = 4'h0;
  localparam logic [3:0] OFF_PORT1 = 4'h1;
  localparam logic [3:0] OFF_PORT2 = 4'h2;
  localparam logic [3:0] OFF_DIR = 4'h3;
  localparam logic [3:0] OFF_BUF = 4'hA;
  localparam logic [3:0] OFF_CHG = 4'hB;
  localparam logic [3:0] OFF_GDIS = 4'hD;
  localparam logic [3:0] OFF_SLEN = 4'hE;
  localparam logic [3:0] OFF_CLR = 4'hF;
  // Direction register fields
  localparam int DIR_CLO = 0;
  localparam int DIR_B = 1;
  localparam int DIR_CHI = 3;
  localparam int DIR_A = 4;
  localparam int DIR_SET = 7;
  localparam logic [7:0] DIR_RD_MASK = 8'h1B;
  localparam logic [7:0] DIR_RESET = 8'h1B;
  // Buffer register: bit 0 disables, bit 1 cleared re-enables
  localparam int BUF_OFF_BIT = 0;
  localparam int BUF_ON_BIT = 1;
  localparam logic [7:0] BUF_RD_SET = 8'h1B;
  // Change-detect enable: 0 enables, one bit per port
  localparam int CHG_A = 0;
  localparam int CHG_B = 1;
  localparam int CHG_C = 2;
  localparam logic [2:0] CHG_RESET = 3'h7;
  localparam int SLEN_BIT = 0;
  localparam int SL_ONE_BIT = 4;
  localparam int SL_IRQ_BIT = 5;
  localparam int SL_LINE = 3;
  // Arbitrary identity values, not tied to any product
  localparam logic [15:0] VENDOR_ID_DEF = 16'h1234;
  localparam logic [15:0] DEVICE_ID_DEF = 16'h5678;

  typedef struct packed {
    logic [7:0] line_in;
    logic [7:0] line_out;
    logic [7:0] line_oe_b;
  } tpdio_port_s;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [3:0] addr;
    logic [7:0] wdata;
  } tpdio_req_s;
endpackage : tpdio_pkg

// File: src/tpdio_line_sync.sv
// Two-stage synchroniser for the 24 port pins with change strobes
`timescale 1ns/10ps
`default_nettype none
module tpdio_line_sync (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [23:0] pin_in,
  output logic [23:0] line_q,
  output logic [23:0] changed
);
  logic [23:0] meta_q;
  logic [23:0] prev_q;
  logic [2:0] fill_q;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= 24'h000000;
      line_q <= 24'h000000;
      prev_q <= 24'h000000;
      fill_q <= 3'h0;
    end else begin
      meta_q <= pin_in;
      line_q <= meta_q;
      prev_q <= line_q;
      fill_q <= {fill_q[1:0], 1'b1};
    end
  end
  // Reset contents are no pin level; mute strobes until all stages hold real samples
  assign changed = {24{fill_q[2]}} & (line_q ^ prev_q);
endmodule : tpdio_line_sync
`default_nettype wire

// File: src/tpdio_core.sv
// Triple 8-bit port digital I/O block with register window, change detect and IRQ
// Function
// RL1: Registers live only in the I/O window region; host uses that region.
// RL2: Offset 0 read returns first port's eight line values in order.
// RL3: Offset 0 write loads first port output latch, driven when output.
// RL4: Offset 1 is second port: read lines, write output latch.
// RL5: Offset 2 is third port: read lines, write output latch.
// RL6: Output-configured port reads back the value being driven.
// RL7: Third port nybbles have independent direction.
// RL8: Direction is set only by the control register at offset 3.
// RL9: Vendor and device identifiers presented for configuration space.
// RL10: Direction bit 1 is input, 0 output; bit 7 must be set.
// RL11: Reset makes every line an input.
// RL12: Any write to offset 0xD disables all interrupt sources.
// RL13: Any write to offset 0xF clears latched status and pending request; here an event in the same cycle keeps irq_q set.
// RL14: Offsets 4 to 9 and 0xC ignore writes and read zero.
// RL15: Four address bits select one of sixteen bytes, single access.
`timescale 1ns/10ps
`default_nettype none
module tpdio_core #(
  parameter logic [15:0] VENDOR_ID = tpdio_pkg::VENDOR_ID_DEF,
  parameter logic [15:0] DEVICE_ID = tpdio_pkg::DEVICE_ID_DEF
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire tpdio_pkg::tpdio_req_s req,
  output logic [7:0] rdata,
  output logic [15:0] vendor_id,
  output logic [15:0] device_id,
  input wire logic [23:0] pin_in,
  output logic [23:0] pin_out,
  output logic [23:0] pin_oe_b,
  output logic irq
);
  logic [23:0] line_q;
  logic [23:0] changed;
  logic [23:0] latch_q;
  logic [2:0] written_q;
  logic [7:0] dir_q;
  logic buf_off_q;
  logic [2:0] chg_dis_q;
  logic sl_en_q;
  logic irq_q;
  logic [7:0] rdata_q;

  tpdio_line_sync u_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .pin_in(pin_in),
    .line_q(line_q),
    .changed(changed)
  );

  assign vendor_id = VENDOR_ID; // RL9
  assign device_id = DEVICE_ID; // RL9

  // Full four-bit decode of the sixteen-byte window
  wire wr_p0 = req.wr && req.addr == tpdio_pkg::OFF_PORT0; // RL15
  wire wr_p1 = req.wr && req.addr == tpdio_pkg::OFF_PORT1;
  wire wr_p2 = req.wr && req.addr == tpdio_pkg::OFF_PORT2;
  wire [2:0] wr_port = {wr_p2, wr_p1, wr_p0};
  wire wr_dir = req.wr && req.addr == tpdio_pkg::OFF_DIR;
  wire wr_buf = req.wr && req.addr == tpdio_pkg::OFF_BUF;
  wire wr_chg = req.wr && req.addr == tpdio_pkg::OFF_CHG;
  wire wr_gdis = req.wr && req.addr == tpdio_pkg::OFF_GDIS; // RL12
  wire wr_sl = req.wr && req.addr == tpdio_pkg::OFF_SLEN;
  wire wr_clr = req.wr && req.addr == tpdio_pkg::OFF_CLR; // RL13
  wire dir_load = wr_dir && req.wdata[tpdio_pkg::DIR_SET]; // RL10

  // Per-line direction: 1 means input
  wire [23:0] line_in_dir = {{4{dir_q[tpdio_pkg::DIR_CHI]}}, {4{dir_q[tpdio_pkg::DIR_CLO]}},
    {8{dir_q[tpdio_pkg::DIR_B]}}, {8{dir_q[tpdio_pkg::DIR_A]}}}; // RL7 RL8
  wire [23:0] line_rd = (line_in_dir & line_q) | (~line_in_dir & latch_q); // RL6

  // Events
  wire sl_rise = sl_en_q && changed[16 + tpdio_pkg::SL_LINE] && line_q[16 + tpdio_pkg::SL_LINE];
  wire chg_hit = (|changed[7:0] && !chg_dis_q[tpdio_pkg::CHG_A]) ||
    (|changed[15:8] && !chg_dis_q[tpdio_pkg::CHG_B]) ||
    (|changed[23:16] && !chg_dis_q[tpdio_pkg::CHG_C]);
  wire irq_event = sl_rise || chg_hit;

  // Port latches; an unwritten port adopts its pins so the switch to output is glitch-free
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_port
      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          latch_q[g*8 +: 8] <= 8'h00;
          written_q[g] <= 1'b0;
        end else if (wr_port[g]) begin // RL3 RL4 RL5
          latch_q[g*8 +: 8] <= req.wdata;
          written_q[g] <= 1'b1;
        end else if (!written_q[g]) begin
          latch_q[g*8 +: 8] <= line_q[g*8 +: 8];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      dir_q <= tpdio_pkg::DIR_RESET; // RL11
    end else if (dir_load) begin
      dir_q <= req.wdata & tpdio_pkg::DIR_RD_MASK; // RL8
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      buf_off_q <= 1'b0;
    end else if (wr_buf && req.wdata[tpdio_pkg::BUF_OFF_BIT]) begin
      buf_off_q <= 1'b1;
    end else if (wr_buf && !req.wdata[tpdio_pkg::BUF_ON_BIT]) begin
      buf_off_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      chg_dis_q <= tpdio_pkg::CHG_RESET;
      sl_en_q <= 1'b0;
    end else if (wr_gdis) begin
      chg_dis_q <= tpdio_pkg::CHG_RESET; // RL12
      sl_en_q <= 1'b0; // RL12
    end else begin
      if (wr_chg) begin
        chg_dis_q <= req.wdata[2:0];
      end
      if (wr_sl) begin
        sl_en_q <= req.wdata[tpdio_pkg::SLEN_BIT];
      end
    end
  end

  // Event in the clear cycle wins so no edge is lost
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irq_q <= 1'b0;
    end else if (irq_event) begin
      irq_q <= 1'b1;
    end else if (wr_clr) begin
      irq_q <= 1'b0; // RL13
    end
  end

  // Read mux; unmapped and write-only offsets read zero
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00; // RL14
    case (req.addr) // RL1
      tpdio_pkg::OFF_PORT0: rd_mux = line_rd[7:0]; // RL2
      tpdio_pkg::OFF_PORT1: rd_mux = line_rd[15:8]; // RL4
      tpdio_pkg::OFF_PORT2: rd_mux = line_rd[23:16]; // RL5
      tpdio_pkg::OFF_DIR: rd_mux = dir_q & tpdio_pkg::DIR_RD_MASK;
      tpdio_pkg::OFF_BUF: rd_mux = buf_off_q ? tpdio_pkg::BUF_RD_SET : 8'h00;
      tpdio_pkg::OFF_CHG: rd_mux = {5'h00, chg_dis_q};
      tpdio_pkg::OFF_SLEN: begin
        rd_mux[tpdio_pkg::SLEN_BIT] = sl_en_q;
        rd_mux[tpdio_pkg::SL_ONE_BIT] = 1'b1;
        rd_mux[tpdio_pkg::SL_IRQ_BIT] = irq_q;
      end
      default: rd_mux = 8'h00; // RL14
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 8'h00;
    end else if (req.rd) begin
      rdata_q <= rd_mux; // RL15
    end
  end

  assign rdata = rdata_q;
  assign irq = irq_q;
  assign pin_out = latch_q; // RL3
  assign pin_oe_b = line_in_dir | {24{buf_off_q}};

  // Checks
  property p_dir_hold;
    @(posedge clk_sys) disable iff (!rst_b)
      (req.wr && req.addr == tpdio_pkg::OFF_DIR && !req.wdata[tpdio_pkg::DIR_SET]) |=>
        $stable(dir_q);
  endproperty
  dir_needs_flag_a: assert property (p_dir_hold) else $error("direction changed without flag"); // RL10
  dir_write_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    dir_load |=> dir_q == ($past(req.wdata) & tpdio_pkg::DIR_RD_MASK))
    else $error("direction not loaded"); // RL8
  sequence s_clear_quiet;
    wr_clr && !irq_event;
  endsequence
  irq_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_clear_quiet |=> !irq) else $error("irq not cleared"); // RL13
  gdis_all_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    wr_gdis |=> !sl_en_q && chg_dis_q == tpdio_pkg::CHG_RESET)
    else $error("sources not disabled"); // RL12
  port0_read_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (req.rd && req.addr == tpdio_pkg::OFF_PORT0) |=> rdata == $past(line_rd[7:0]))
    else $error("port read wrong"); // RL2
  port_drive_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    wr_p1 |=> pin_out[15:8] == $past(req.wdata)) else $error("latch not loaded"); // RL4
  unused_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (req.rd && req.addr inside {[4'h4:4'h9], 4'hC}) |=> rdata == 8'h00)
    else $error("unused offset nonzero"); // RL14
  readback_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (req.rd && req.addr == tpdio_pkg::OFF_PORT2 && !dir_q[tpdio_pkg::DIR_CLO]) |=>
      rdata[3:0] == $past(latch_q[19:16])) else $error("readback wrong"); // RL6 RL7
  reset_input_a: assert property (@(posedge clk_sys) $rose(rst_b) |-> &pin_oe_b)
    else $error("line driven after reset"); // RL11
endmodule : tpdio_core
`default_nettype wire

// File: verif/tpdio_pins_model.sv
// Field-side line model: pull-ups plus optional external drivers
`timescale 1ns/10ps
`default_nettype none
module tpdio_pins_model (
  input wire logic [23:0] pin_out,
  input wire logic [23:0] pin_oe_b,
  input wire logic [23:0] ext_val,
  input wire logic [23:0] ext_en,
  output logic [23:0] pin_in
);
  // Released lines rest at the pull-up level, never at the last value
  always_comb begin
    for (int i = 0; i < 24; i++) begin
      pin_in[i] = !pin_oe_b[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
    end
  end
endmodule : tpdio_pins_model
`default_nettype wire

// File: verif/testbench.sv
// Self-checking bench for the triple-port digital I/O block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  tpdio_pkg::tpdio_req_s req = '0;
  logic [23:0] ext_val = 24'h0;
  logic [23:0] ext_en = 24'h0;
  logic [7:0] rdata;
  logic [7:0] rd_v;
  logic [15:0] vid;
  logic [15:0] did;
  logic [23:0] pin_in;
  logic [23:0] pin_out;
  logic [23:0] pin_oe_b;
  logic irq;
  int n_fail = 0;
  int n_tests = 0;
  int lat[3];
  int dirv;
  int dt[6] = '{'h00, 'h1B, 'h18, 'h03, 'h01, 'h08};
  always #5 clk_sys = ~clk_sys;
  tpdio_core dut (.clk_sys(clk_sys), .rst_b(rst_b), .req(req), .rdata(rdata),
    .vendor_id(vid), .device_id(did), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_b(pin_oe_b), .irq(irq));
  tpdio_pins_model pins (.pin_out(pin_out), .pin_oe_b(pin_oe_b), .ext_val(ext_val),
    .ext_en(ext_en), .pin_in(pin_in));
  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(negedge clk_sys);
    req.wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(negedge clk_sys);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge clk_sys);
    req.rd = 1'b0;
    rd_v = rdata;
  endtask : rd
  function automatic logic [23:0] oe_exp(input int d);
    oe_exp = {{4{d[3]}}, {4{d[0]}}, {8{d[1]}}, {8{d[4]}}};
  endfunction : oe_exp
  task automatic chk_ports();
    logic [23:0] oe;
    logic [23:0] e;
    oe = oe_exp(dirv);
    e = (~oe & {8'(lat[2]), 8'(lat[1]), 8'(lat[0])}) | (oe & ((ext_en & ext_val) | ~ext_en));
    repeat (3) @(negedge clk_sys);
    chk("pin_oe_b", pin_oe_b, oe);
    chk("pin_out", pin_out, {8'(lat[2]), 8'(lat[1]), 8'(lat[0])});
    for (int i = 0; i < 3; i++) begin
      rd(4'(i));
      chk("port", {16'h0, rd_v}, {16'h0, e[8*i +: 8]});
    end
  endtask : chk_ports
  task automatic test_done();
    $display("Checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done
  initial begin
    #100000;
    n_fail++;
    test_done();
  end
  initial begin
    void'($urandom(40));
    repeat (2) @(negedge clk_sys);
    rst_b = 1'b1;
    chk("oe reset", pin_oe_b, 24'hFFFFFF);
    chk("vendor", {8'h0, vid}, {8'h0, tpdio_pkg::VENDOR_ID_DEF});
    chk("device", {8'h0, did}, {8'h0, tpdio_pkg::DEVICE_ID_DEF});
    wr(4'h3, 8'h00);
    rd(4'h3);
    chk("dir no flag", {16'h0, rd_v}, 24'h00001B);
    $display("test reset done");
    foreach (dt[k]) begin
      for (int i = 0; i < 3; i++) begin
        lat[i] = $urandom & 'hFF;
        wr(4'(i), 8'(lat[i]));
      end
      ext_val = 24'($urandom);
      ext_en = 24'($urandom);
      dirv = dt[k];
      wr(4'h3, 8'(dirv | 'h80));
      rd(4'h3);
      chk("dir", {16'h0, rd_v}, 24'(dirv));
      chk_ports();
    end
    $display("test directions done");
    foreach (dt[k]) begin
      wr(4'(k + 4), 8'($urandom));
      rd(4'(k + 4));
      chk("unused", {16'h0, rd_v}, 24'h0);
    end
    wr(4'hC, 8'hFF);
    rd(4'hC);
    chk("unused C", {16'h0, rd_v}, 24'h0);
    chk_ports();
    $display("test unused done");
    wr(4'hA, 8'h01);
    rd(4'hA);
    chk("buf off", {16'h0, rd_v}, 24'h00001B);
    chk("buf oe", pin_oe_b, 24'hFFFFFF);
    wr(4'hA, 8'h00);
    rd(4'hA);
    chk("buf on", {16'h0, rd_v}, 24'h0);
    chk_ports();
    $display("test buffer done");
    dirv = 'h1B;
    wr(4'h3, 8'h9B);
    ext_en = 24'hFFFFFF;
    ext_val = 24'h0;
    wr(4'hE, 8'h01);
    rd(4'hE);
    chk("sl en", {16'h0, rd_v}, 24'h000011);
    ext_val[19] = 1'b1;
    repeat (5) @(negedge clk_sys);
    chk("irq set", {23'h0, irq}, 24'h1);
    rd(4'hE);
    chk("irq stat", {16'h0, rd_v}, 24'h000031);
    wr(4'hF, 8'h5A);
    @(negedge clk_sys);
    chk("irq clr", {23'h0, irq}, 24'h0);
    wr(4'hE, 8'h00);
    wr(4'hB, 8'h06);
    ext_val[0] = 1'b1;
    repeat (5) @(negedge clk_sys);
    chk("chg irq", {23'h0, irq}, 24'h1);
    wr(4'hF, 8'h00);
    wr(4'hD, 8'hA5);
    ext_val[0] = 1'b0;
    repeat (5) @(negedge clk_sys);
    chk("irq gdis", {23'h0, irq}, 24'h0);
    rd(4'hB);
    chk("chg off", {16'h0, rd_v}, 24'h000007);
    $display("test irq done");
    rst_b = 1'b0;
    repeat (2) @(negedge clk_sys);
    rst_b = 1'b1;
    dirv = 'h1B;
    chk("oe reset again", pin_oe_b, 24'hFFFFFF);
    rd(4'h3);
    chk("dir reset again", {16'h0, rd_v}, 24'h00001B);
    rd(4'hE);
    chk("sl reset again", {16'h0, rd_v}, 24'h000010);
    $display("test reset again done");
    test_done();
  end
endmodule : testbench
`default_nettype wire
